// ==== logic/sice_pkg.sv ====
// Constants, codes and types shared by the safety input channel evaluator.
// Assumes a 10 MHz ref_clk and a plain single-cycle register port.
package sice_pkg;
    // Bus and channel sizes.
    localparam int DW = 16;
    localparam int AW = 3;
    localparam int NUM_CH = 4;
    localparam int TYPE_W = 3;
    localparam int NUM_EV = 5;
    typedef logic [DW-1:0] sice_word_t;
    typedef logic [AW-1:0] sice_addr_t;
    typedef logic [TYPE_W-1:0] sice_type_t;

    // Register offsets.
    localparam sice_addr_t A_CTRL = 3'h0;
    localparam sice_addr_t A_DISC = 3'h1;
    localparam sice_addr_t A_SYNC = 3'h2;
    localparam sice_addr_t A_STAT = 3'h3;
    localparam sice_addr_t A_MASK = 3'h4;
    localparam sice_addr_t A_STATE = 3'h5;

    // Input type codes.
    localparam sice_type_t IT_SINGLE = 3'h0;
    localparam sice_type_t IT_DEQ = 3'h1;
    localparam sice_type_t IT_DCOMP = 3'h2;
    localparam sice_type_t IT_DEQ2 = 3'h3;
    localparam sice_type_t IT_DCOMP2 = 3'h4;

    // Control fields.
    localparam int C_TYPE_LSB = 0;
    localparam int C_GATE = 3;
    localparam int C_FTEST = 4;
    localparam int C_FPOUT = 5;
    localparam int C_TPOUT = 6;

    // Status event bits and state fields.
    localparam int S_DISC0 = 0;
    localparam int S_DISC1 = 1;
    localparam int S_SYNC = 2;
    localparam int S_FTREQ = 3;
    localparam int S_FTDONE = 4;
    localparam int T_OE = 0;
    localparam int T_ERR = 1;
    localparam int T_TEST = 2;
    localparam int T_IN_LSB = 3;

    // Reset values.
    localparam sice_word_t CTRL_RST = 16'h0000;
    localparam sice_word_t TIME_RST = 16'h0003;
    localparam sice_word_t ZERO_W = 16'h0000;

    // Time base: one time unit is 10 ms.
    localparam int TICK_NS = 10_000_000;
    localparam int CLK_NS = 100;
    localparam int TICK_CYC = TICK_NS / CLK_NS;

    // Evaluator states.
    typedef enum logic [2:0] {
        ST_RUN = 3'b001,
        ST_ERR = 3'b010,
        ST_TEST = 3'b100
    } sice_state_t;
endpackage : sice_pkg

// ==== logic/sice_pair_if.sv ====
// Signals between the evaluator top and one channel pair monitor.
// Assumes both ends run on the same ref_clk.
`timescale 1ns/1ns
interface sice_pair_if;
    logic ch_a;
    logic ch_b;
    logic comp;
    logic chk_en;
    logic tick;
    sice_pkg::sice_word_t limit;
    logic active;
    logic inactive;
    logic timeout;
    modport mon (input ch_a, ch_b, comp, chk_en, tick, limit,
                 output active, inactive, timeout);
    modport ctl (output ch_a, ch_b, comp, chk_en, tick, limit,
                 input active, inactive, timeout);
endinterface : sice_pair_if

// ==== logic/sice_pair_mon.sv ====
// Classifies one channel pair and times how long it stays discrepant.
// Assumes filtered inputs and a one-cycle time-base tick from the top.
`timescale 1ns/1ns
module sice_pair_mon (
    input wire logic ref_clk,
    input wire logic sys_rst,
    sice_pair_if.mon pif
);
    import sice_pkg::*;

    logic disc;
    logic armed;
    sice_word_t cnt;
    logic fired;
    logic to_q;

    // Pair classification for equivalent and complementary wiring.
    assign pif.active = pif.comp ? (pif.ch_a & ~pif.ch_b) : (pif.ch_a & pif.ch_b); // RULE9
    assign pif.inactive = pif.comp ? (~pif.ch_a & pif.ch_b) : (~pif.ch_a & ~pif.ch_b); // RULE9
    assign disc = ~pif.active & ~pif.inactive;
    // A zero limit switches the timing off.
    assign armed = pif.chk_en & (pif.limit != ZERO_W) & disc; // RULE7 RULE10
    assign pif.timeout = to_q;

    // Counts ticks while discrepant in either direction of change.
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cnt <= ZERO_W;
            fired <= 1'b0;
            to_q <= 1'b0;
        end else if (!armed) begin
            cnt <= ZERO_W; // RULE11
            fired <= 1'b0;
            to_q <= 1'b0;
        end else if (pif.tick && !fired) begin
            cnt <= cnt + 16'h0001;
            fired <= (cnt + 16'h0001) >= pif.limit;
            to_q <= (cnt + 16'h0001) >= pif.limit; // RULE8
        end else begin
            to_q <= 1'b0;
        end
    end

    // Checks on the pair timer.
    AST_DISC_ZERO: assert property (@(posedge ref_clk) disable iff (sys_rst) // RULE10
        (pif.limit == ZERO_W) |=> !pif.timeout)
        else $error("Pair timed out with zero limit.");
    AST_DISC_MODE: assert property (@(posedge ref_clk) disable iff (sys_rst) // RULE7
        !pif.chk_en |=> !pif.timeout)
        else $error("Pair timed out while checking was off.");
    AST_DISC_PULSE: assert property (@(posedge ref_clk) disable iff (sys_rst) // RULE8
        pif.timeout |=> !pif.timeout)
        else $error("Pair timeout lasted more than one cycle.");
endmodule : sice_pair_mon

// ==== logic/sice_top.sv ====
// Safety input channel evaluator: truth tables, pair and sync timing.
// Assumes field contacts on safety_in and a single-cycle register port.
//
// Operation
// RULE1: Input type selects single, dual eq, dual comp, or their two-pair forms.
// RULE2: Levels are 0 off, 1 on; single mode output enable follows input one.
// RULE3: Dual equivalent enables output only when both inputs are one.
// RULE4: Dual complementary enables only when closed input is one, open is zero.
// RULE5: Two-pair equivalent enables only when all four inputs are one.
// RULE6: Two-pair complementary needs inputs one, three high and two, four low.
// RULE7: Discrepancy timing applies only in dual input types.
// RULE8: Other channel not following within discrepancy time flags error, output off.
// RULE9: Pair states are classed active, inactive or discrepant per wiring.
// RULE10: A discrepancy time of zero disables pair timing.
// RULE11: Discrepancy timing applies to both activating and deactivating changes.
// RULE12: Gate monitor in two-pair modes may time the change between pairs.
// RULE13: Second pair not following within sync time raises error, output off.
// RULE14: A sync time of zero disables pair-to-pair timing.
// RULE15: With function test enabled, each machine request demands a gate test; code honours a request only with the gate bit also set and from the run state.
// RULE16: An enabled fault-present output mirrors the block fault status.
// RULE17: Optional outputs can be individually enabled.
// RULE18: Errors stay latched, output off, until all channels return inactive.
`timescale 1ns/1ns
module sice_top #(
    parameter int TICK_CYC = sice_pkg::TICK_CYC
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic [sice_pkg::NUM_CH-1:0] safety_in,
    input wire logic ftest_req_in,
    input wire sice_pkg::sice_addr_t reg_addr,
    input wire sice_pkg::sice_word_t reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output sice_pkg::sice_word_t reg_rdata,
    output logic output_enable,
    output logic fault_present,
    output logic test_pending,
    output logic irq
);
    import sice_pkg::*;

    localparam int NS = NUM_CH + 1;
    localparam int TW = $clog2(TICK_CYC + 1);
    localparam logic [TW-1:0] TICK_LAST = TW'(TICK_CYC - 1);
    localparam logic [TW-1:0] TICK_ZERO = '0;

    // Input synchronisers and filtered levels.
    logic [NS-1:0] sy1;
    logic [NS-1:0] sy2;
    logic [NS-1:0] sy3;
    logic [NS-1:0] filt;
    logic [NUM_CH-1:0] ch;
    logic ft_lvl;
    logic ft_prev;
    logic ft_rise;

    // Registers.
    sice_word_t ctrl;
    sice_word_t disc_time;
    sice_word_t sync_time;
    logic [NUM_EV-1:0] status;
    logic [NUM_EV-1:0] mask;
    logic [NUM_EV-1:0] ev;
    logic [NUM_EV-1:0] clr;

    // Mode decode.
    sice_type_t ityp;
    logic is_dual;
    logic is_two;
    logic is_comp;
    logic raw_oe;

    // Timing.
    logic [TW-1:0] tcnt;
    logic tick;
    logic [1:0] act;
    logic [1:0] ina;
    logic [1:0] pto;
    logic all_ina;
    logic sy_arm;
    sice_word_t scnt;
    logic sfired;
    logic sync_to;
    logic fault;

    sice_state_t state;
    sice_state_t next_state;

    // Three-stage synchroniser on every pin.
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            sy1 <= '0;
            sy2 <= '0;
            sy3 <= '0;
        end else begin
            sy1 <= {ftest_req_in, safety_in};
            sy2 <= sy1;
            sy3 <= sy2;
        end
    end

    // A change counts once the second and third stage agree.
    for (genvar i = 0; i < NS; i++) begin : g_filt
        always_ff @(posedge ref_clk or posedge sys_rst) begin
            if (sys_rst) begin
                filt[i] <= 1'b0;
            end else if (sy2[i] == sy3[i]) begin
                filt[i] <= sy3[i];
            end
        end
    end

    assign ch = filt[NUM_CH-1:0];
    assign ft_lvl = filt[NUM_CH];
    assign ft_rise = ft_lvl & ~ft_prev;

    // Edge memory for the function test request.
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ft_prev <= 1'b0;
        end else begin
            ft_prev <= ft_lvl;
        end
    end

    // Software-written configuration registers.
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ctrl <= CTRL_RST;
            disc_time <= TIME_RST;
            sync_time <= TIME_RST;
            mask <= '0;
        end else if (reg_wr) begin
            if (reg_addr == A_CTRL) begin
                ctrl <= reg_wdata; // RULE1 RULE17
            end
            if (reg_addr == A_DISC) begin
                disc_time <= reg_wdata;
            end
            if (reg_addr == A_SYNC) begin
                sync_time <= reg_wdata;
            end
            if (reg_addr == A_MASK) begin
                mask <= reg_wdata[NUM_EV-1:0];
            end
        end
    end

    // Input type decode.
    assign ityp = ctrl[C_TYPE_LSB +: TYPE_W]; // RULE1
    assign is_two = (ityp == IT_DEQ2) | (ityp == IT_DCOMP2);
    assign is_dual = is_two | (ityp == IT_DEQ) | (ityp == IT_DCOMP); // RULE7
    assign is_comp = (ityp == IT_DCOMP) | (ityp == IT_DCOMP2);

    // Truth tables per input type; unknown codes keep the output off.
    always_comb begin
        unique case (ityp)
            IT_SINGLE: raw_oe = ch[0]; // RULE2
            IT_DEQ: raw_oe = ch[0] & ch[1]; // RULE3
            IT_DCOMP: raw_oe = ch[0] & ~ch[1]; // RULE4
            IT_DEQ2: raw_oe = &ch; // RULE5
            IT_DCOMP2: raw_oe = ch[0] & ~ch[1] & ch[2] & ~ch[3]; // RULE6
            default: raw_oe = 1'b0;
        endcase
    end

    // Time base of one tick per time unit.
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            tcnt <= TICK_ZERO;
        end else if (tcnt == TICK_LAST) begin
            tcnt <= TICK_ZERO;
        end else begin
            tcnt <= tcnt + TW'(1);
        end
    end

    assign tick = (tcnt == TICK_LAST);

    // One discrepancy monitor per channel pair.
    sice_pair_if pif [2] ();
    for (genvar p = 0; p < 2; p++) begin : g_pair
        assign pif[p].ch_a = ch[2*p];
        assign pif[p].ch_b = ch[2*p+1];
        assign pif[p].comp = is_comp;
        assign pif[p].chk_en = (p == 0) ? is_dual : is_two; // RULE7
        assign pif[p].tick = tick;
        assign pif[p].limit = disc_time;
        assign act[p] = pif[p].active;
        assign ina[p] = pif[p].inactive;
        assign pto[p] = pif[p].timeout;
        sice_pair_mon u_mon (
            .ref_clk(ref_clk),
            .sys_rst(sys_rst),
            .pif(pif[p])
        );
    end

    // Every monitored channel back in its inactive state.
    always_comb begin
        if (is_two) begin
            all_ina = &ina;
        end else if (is_dual) begin
            all_ina = ina[0];
        end else begin
            all_ina = ~ch[0];
        end
    end

    // Pair-to-pair timing for the gate monitor in two-pair modes.
    assign sy_arm = is_two & ctrl[C_GATE] & (sync_time != ZERO_W) // RULE12 RULE14
                    & ((act[0] != act[1]) | (ina[0] != ina[1]));

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            scnt <= ZERO_W;
            sfired <= 1'b0;
            sync_to <= 1'b0;
        end else if (!sy_arm) begin
            scnt <= ZERO_W;
            sfired <= 1'b0;
            sync_to <= 1'b0;
        end else if (tick && !sfired) begin
            scnt <= scnt + 16'h0001;
            sfired <= (scnt + 16'h0001) >= sync_time;
            sync_to <= (scnt + 16'h0001) >= sync_time; // RULE13
        end else begin
            sync_to <= 1'b0;
        end
    end

    assign fault = pto[0] | pto[1] | sync_to;

    // Evaluator state: errors win over tests and hold until all inactive.
    always_comb begin
        next_state = state;
        unique case (state)
            ST_RUN: begin
                if (fault) begin
                    next_state = ST_ERR; // RULE8 RULE13
                end else if (ft_rise && ctrl[C_FTEST] && ctrl[C_GATE]) begin
                    next_state = ST_TEST; // RULE15
                end
            end
            ST_ERR: begin
                if (all_ina && !fault) begin
                    next_state = ST_RUN; // RULE18
                end
            end
            ST_TEST: begin
                if (fault) begin
                    next_state = ST_ERR;
                end else if (all_ina) begin
                    next_state = ST_RUN; // RULE15
                end
            end
            default: next_state = ST_ERR;
        endcase
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state <= ST_RUN;
        end else begin
            state <= next_state;
        end
    end

    // Registered outputs; optional ones gated by their enable bits.
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            output_enable <= 1'b0;
            fault_present <= 1'b0;
            test_pending <= 1'b0;
        end else begin
            output_enable <= (next_state == ST_RUN) & raw_oe; // RULE8 RULE13 RULE18
            fault_present <= ctrl[C_FPOUT] & (next_state == ST_ERR); // RULE16 RULE17
            test_pending <= ctrl[C_TPOUT] & (next_state == ST_TEST); // RULE17
        end
    end

    // Events for the sticky status register.
    assign ev[S_DISC0] = pto[0];
    assign ev[S_DISC1] = pto[1];
    assign ev[S_SYNC] = sync_to;
    assign ev[S_FTREQ] = ft_rise;
    assign ev[S_FTDONE] = (state == ST_TEST) & (next_state == ST_RUN);
    assign clr = (reg_wr && reg_addr == A_STAT) ? reg_wdata[NUM_EV-1:0] : '0;

    // Write one to clear; a new event in the same cycle wins.
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            status <= '0;
        end else begin
            status <= (status & ~clr) | ev;
        end
    end

    assign irq = |(status & mask);

    // Read data appears the cycle after the read strobe, else zero.
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            reg_rdata <= ZERO_W;
        end else if (!reg_rd) begin
            reg_rdata <= ZERO_W;
        end else begin
            unique case (reg_addr)
                A_CTRL: reg_rdata <= ctrl;
                A_DISC: reg_rdata <= disc_time;
                A_SYNC: reg_rdata <= sync_time;
                A_STAT: reg_rdata <= DW'(status);
                A_MASK: reg_rdata <= DW'(mask);
                A_STATE: reg_rdata <= DW'({ch, state == ST_TEST,
                                           state == ST_ERR, output_enable});
                default: reg_rdata <= ZERO_W;
            endcase
        end
    end

    // Fault followed by the output held off.
    sequence s_fault;
        fault;
    endsequence

    sequence s_held_off;
        (state == ST_ERR) && !output_enable;
    endsequence

    AST_FAULT_OFF: assert property (@(posedge ref_clk) disable iff (sys_rst) // RULE8
        s_fault |=> s_held_off)
        else $error("Fault did not force the error state.");
    AST_SINGLE: assert property (@(posedge ref_clk) disable iff (sys_rst) // RULE2
        (ityp == IT_SINGLE && next_state == ST_RUN) |=> output_enable == $past(ch[0]))
        else $error("Single mode output does not follow input one.");
    AST_DEQ: assert property (@(posedge ref_clk) disable iff (sys_rst) // RULE3
        (ityp == IT_DEQ && !(ch[0] && ch[1])) |=> !output_enable)
        else $error("Dual equivalent enabled with an input off.");
    AST_DCOMP: assert property (@(posedge ref_clk) disable iff (sys_rst) // RULE4
        (ityp == IT_DCOMP && (ch[1] || !ch[0])) |=> !output_enable)
        else $error("Dual complementary enabled with bad inputs.");
    AST_DEQ2: assert property (@(posedge ref_clk) disable iff (sys_rst) // RULE5
        (ityp == IT_DEQ2 && !(&ch)) |=> !output_enable)
        else $error("Two-pair equivalent enabled with an input off.");
    AST_DCOMP2: assert property (@(posedge ref_clk) disable iff (sys_rst) // RULE6
        (ityp == IT_DCOMP2 && ch != 4'h5) |=> !output_enable)
        else $error("Two-pair complementary enabled with bad inputs.");
    AST_ERR_HOLD: assert property (@(posedge ref_clk) disable iff (sys_rst) // RULE18
        (state == ST_ERR && !all_ina) |=> state == ST_ERR)
        else $error("Error released before all channels went inactive.");
    AST_SYNC_ZERO: assert property (@(posedge ref_clk) disable iff (sys_rst) // RULE14
        (sync_time == ZERO_W) |=> !sync_to)
        else $error("Sync timeout with zero sync time.");
    AST_FTEST: assert property (@(posedge ref_clk) disable iff (sys_rst) // RULE15
        (state == ST_RUN && !fault && ft_rise && ctrl[C_FTEST] && ctrl[C_GATE])
        |=> state == ST_TEST ##1 !output_enable)
        else $error("Function test request not honoured.");
    AST_STICKY: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (ev[S_DISC0] && clr[S_DISC0]) |=> status[S_DISC0])
        else $error("Event lost against a clear.");
endmodule : sice_top

// ==== dv/sice_field_dev.sv ====
// Field side model: two dual-channel safety contacts and the machine's test request.
// Assumes the bench changes its commands right after a rising ref_clk edge.
`timescale 1ns/1ns
module sice_field_dev (
    input wire logic ref_clk,
    input wire logic [3:0] want,
    input wire logic [3:0] stuck,
    input wire logic [4:0] lag,
    input wire logic req_cmd,
    output logic [3:0] safety_in,
    output logic ftest_req_in
);
    logic [3:0] hist [0:15];

    // Contacts start open, as after power up.
    initial begin
        safety_in = 4'h0;
        ftest_req_in = 1'b0;
    end

    // The second channel of each pair trails the first by lag cycles; a stuck contact holds.
    always @(posedge ref_clk) begin
        hist[0] <= want;
        for (int i = 1; i < 16; i++) begin
            hist[i] <= hist[i-1];
        end
        for (int i = 0; i < 4; i++) begin
            if (!stuck[i]) begin
                safety_in[i] <= (i % 2 == 1 && lag != 5'h00) ? hist[lag-1][i] : want[i];
            end
        end
    end

    // The machine presents its test request as a level.
    always @(posedge ref_clk) begin
        ftest_req_in <= req_cmd;
    end
endmodule : sice_field_dev

// ==== dv/tb.sv ====
// Self-checking bench for the safety input channel evaluator.
// Assumes the field model drives the contacts and TICK_CYC is cut to 4 cycles.
`timescale 1ns/1ns
module tb;
    import sice_pkg::*;
    logic ref_clk, sys_rst, reg_wr, reg_rd, req_cmd, ftest_req_in;
    logic output_enable, fault_present, test_pending, irq;
    sice_addr_t reg_addr;
    sice_word_t reg_wdata, reg_rdata, rd;
    logic [3:0] want, stuck, pins;
    logic [4:0] lag;
    int mismatches, checks;
    sice_word_t rst_tab [0:6] = '{16'h0000, 16'h0003, 16'h0003, 16'h0000, 16'h0000,
                                  16'h0000, 16'h0000};

    sice_field_dev dev (.ref_clk(ref_clk), .want(want), .stuck(stuck), .lag(lag),
        .req_cmd(req_cmd), .safety_in(pins), .ftest_req_in(ftest_req_in));
    sice_top #(.TICK_CYC(4)) uut (.ref_clk(ref_clk), .sys_rst(sys_rst), .safety_in(pins),
        .ftest_req_in(ftest_req_in), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .output_enable(output_enable), .fault_present(fault_present),
        .test_pending(test_pending), .irq(irq));

    // Clock of 100 ns period.
    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end

    task automatic finish_test;
        $display("mismatches=%0d checks=%0d", mismatches, checks);
        if (mismatches == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : finish_test

    task automatic chk_word(input sice_word_t got, input sice_word_t exp);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_word

    task automatic chk_bit(input logic got, input logic exp);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_bit

    task automatic wt(input int n);
        repeat (n) @(posedge ref_clk);
    endtask : wt

    // One-cycle write, then an idle cycle so the strobe is never set twice at one edge.
    task automatic wr(input sice_addr_t a, input sice_word_t d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        @(posedge ref_clk);
    endtask : wr

    // One-cycle read; data stand only in the following cycle.
    task automatic rdc(input sice_addr_t a, input sice_word_t exp);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 rd = reg_rdata;
        @(posedge ref_clk);
        chk_word(rd, exp);
    endtask : rdc

    task automatic drive(input logic [3:0] w, input logic [4:0] l, input logic [3:0] s);
        want <= w;
        lag <= l;
        stuck <= s;
    endtask : drive

    function automatic logic exp_oe(input sice_type_t t, input logic [3:0] p);
        case (t)
            IT_SINGLE: return p[0];
            IT_DEQ: return p[0] & p[1];
            IT_DCOMP: return p[0] & !p[1];
            IT_DEQ2: return &p;
            default: return p[0] & !p[1] & p[2] & !p[3];
        endcase
    endfunction : exp_oe

    // Hang guard.
    initial begin
        wt(30000);
        mismatches++;
        finish_test();
    end

    // Main sequence.
    initial begin
        {sys_rst, reg_wr, reg_rd, req_cmd} = 4'h8;
        {reg_addr, reg_wdata, want, stuck, lag} = '0;
        mismatches = 0;
        checks = 0;
        wt(12);
        sys_rst <= 1'b0;
        wt(1);
        for (int a = 0; a < 7; a++) begin
            rdc(sice_addr_t'(a), rst_tab[a]);
        end
        wr(A_STATE, 16'hffff);
        rdc(A_STATE, 16'h0000);
        // Every input type against every contact pattern, timing off.
        wr(A_DISC, 16'h0000);
        wr(A_SYNC, 16'h0000);
        for (int t = 0; t < 5; t++) begin
            wr(A_CTRL, 16'h0008 | 16'(t));
            for (int p = 0; p < 16; p++) begin
                drive(4'(p), 5'h00, 4'h0);
                wt(20);
                chk_bit(output_enable, exp_oe(sice_type_t'(t), 4'(p)));
            end
        end
        rdc(A_STAT, 16'h0000);
        drive(4'h5, 5'h00, 4'h0);
        wt(10);
        rdc(A_STATE, 16'h0029);
        drive(4'h0, 5'h00, 4'h0);
        wr(A_STAT, 16'h001f);
        // Discrepancy timing on one pair with 8 ticks allowed.
        wr(A_CTRL, 16'h0021);
        wr(A_DISC, 16'h0008);
        drive(4'h3, 5'h0c, 4'h0);
        wt(30);
        chk_bit(output_enable, 1'b1);
        rdc(A_STAT, 16'h0000);
        drive(4'h0, 5'h00, 4'h2);
        wt(20);
        rdc(A_STAT, 16'h0000);
        wt(25);
        rdc(A_STAT, 16'h0001);
        chk_bit(output_enable, 1'b0);
        chk_bit(fault_present, 1'b1);
        chk_bit(irq, 1'b0);
        wr(A_MASK, 16'h0001);
        chk_bit(irq, 1'b1);
        drive(4'h0, 5'h00, 4'h0);
        wt(10);
        chk_bit(fault_present, 1'b0);
        wr(A_STAT, 16'h0001);
        chk_bit(irq, 1'b0);
        drive(4'h3, 5'h00, 4'h2);
        wt(45);
        rdc(A_STAT, 16'h0001);
        drive(4'h3, 5'h00, 4'h0);
        wt(10);
        chk_bit(output_enable, 1'b0);
        drive(4'h0, 5'h00, 4'h0);
        wt(10);
        drive(4'h3, 5'h00, 4'h0);
        wt(10);
        chk_bit(output_enable, 1'b1);
        // Single channel never times a pair.
        wr(A_CTRL, 16'h0000);
        wr(A_STAT, 16'h001f);
        drive(4'h1, 5'h00, 4'h0);
        wt(45);
        rdc(A_STAT, 16'h0000);
        chk_bit(output_enable, 1'b1);
        // Pair-to-pair timing with 4 ticks allowed.
        drive(4'h0, 5'h00, 4'h0);
        wr(A_CTRL, 16'h002b);
        wr(A_DISC, 16'h0000);
        wr(A_SYNC, 16'h0004);
        wr(A_MASK, 16'h0004);
        wt(10);
        drive(4'hf, 5'h00, 4'hc);
        wt(10);
        rdc(A_STAT, 16'h0000);
        wt(20);
        rdc(A_STAT, 16'h0004);
        chk_bit(output_enable, 1'b0);
        chk_bit(irq, 1'b1);
        drive(4'h0, 5'h00, 4'h0);
        wt(10);
        wr(A_STAT, 16'h001f);
        drive(4'hf, 5'h00, 4'h0);
        wt(30);
        chk_bit(output_enable, 1'b1);
        rdc(A_STAT, 16'h0000);
        // Function test requested by the machine.
        wr(A_SYNC, 16'h0000);
        wr(A_CTRL, 16'h005b);
        req_cmd <= 1'b1;
        wt(8);
        chk_bit(test_pending, 1'b1);
        chk_bit(output_enable, 1'b0);
        rdc(A_STAT, 16'h0008);
        req_cmd <= 1'b0;
        drive(4'h0, 5'h00, 4'h0);
        wt(10);
        chk_bit(test_pending, 1'b0);
        rdc(A_STAT, 16'h0018);
        drive(4'hf, 5'h00, 4'h0);
        wt(10);
        chk_bit(output_enable, 1'b1);
        finish_test();
    end
endmodule : tb
